// ===== logic/slp_line_ctrl.sv
// Line parameter control: APB registers, framing and parity for sender and receiver
//
// Function
// RL1: Bits 13:12 select internal, external sync, isochronous
// RL2: Software writes only defined mode codes
// RL3: Bits 11:10 set length five to eight
// RL4: Parity enable generates and checks parity
// RL5: Short characters expose received parity in buffer
// RL6: Bit 8 set even, clear odd parity
// RL7: Data right justified, parity next higher bit
// RL8: Low byte is sync character and fill
// RL9: New settings apply to next framed character
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module slp_line_ctrl
	import slp_pkg::*;
#(
	parameter logic [15:0] BIT_DIVIDE = BIT_DIV
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_line,
	input wire logic ext_clk,
	output logic tx_line,
	output logic mode_error
);
	function automatic slp_frame_s decode(input logic [15:0] r);
		slp_frame_s f;
		unique case (r[MODE_HI:MODE_LO]) // RL1
			MODE_INT_SYNC: f.mode = SLP_INT_SYNC;
			MODE_EXT_SYNC: f.mode = SLP_EXT_SYNC;
			default: f.mode = SLP_ISOCH;
		endcase
		f.len = LEN_BASE + {2'h0, r[LEN_HI:LEN_LO]}; // RL3
		f.par_on = r[PAR_ON_BIT];
		f.par_even = r[PAR_SENSE_BIT];
		return f;
	endfunction : decode

	logic [15:0] setup_q, setup_d;
	logic [7:0] txd_q, txd_d;
	logic txv_q, txv_d;
	logic [7:0] rxbuf_q, rxbuf_d;
	logic rxdone_q, rxdone_d, perr_q, perr_d, sync_q, sync_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [15:0] div_q, div_d;
	logic [2:0] ext_s_q, ext_s_d, rx_s_q, rx_s_d;
	logic bit_en;
	slp_frame_s cfg, rx_cfg_q, rx_cfg_d;
	logic [8:0] rsh_q, rsh_d;
	logic [3:0] rcnt_q, rcnt_d;
	logic rbusy_q, rbusy_d;
	logic tx_start, tx_busy;
	logic [7:0] tx_byte;
	logic setup_fire, acc;

	assign cfg = decode(setup_q);
	assign acc = psel && penable && !pready_q;
	assign setup_fire = acc && pwrite && paddr == ADDR_SETUP;

	// APB: one wait state, answer registered
	always_comb
	begin
		setup_d = setup_q;
		txd_d = txd_q;
		txv_d = txv_q;
		prdata_d = prdata_q;
		pready_d = acc;
		pslverr_d = 1'b0;
		if (tx_start)
			txv_d = 1'b0;
		if (acc)
		begin
			prdata_d = '0;
			unique case (paddr)
				ADDR_SETUP: if (pwrite) setup_d = pwdata[15:0];
				ADDR_STATUS: prdata_d = {29'h0, sync_q, perr_q, rxdone_q};
				ADDR_RXBUF: prdata_d = {24'h0, rxbuf_q};
				ADDR_TXDATA:
					if (pwrite)
					begin
						txd_d = pwdata[7:0];
						txv_d = 1'b1;
					end
				default: pslverr_d = 1'b1;
			endcase
		end
	end

	// Bit timing: divider for internal sync, synchronised modem clock otherwise
	always_comb
	begin
		ext_s_d = {ext_s_q[1:0], ext_clk};
		rx_s_d = {rx_s_q[1:0], rx_line};
		div_d = div_q + 16'h1;
		if (div_q >= BIT_DIVIDE - 16'h1)
			div_d = '0;
		bit_en = (cfg.mode == SLP_INT_SYNC) ? (div_q == '0) : (ext_s_q[1] && !ext_s_q[2]);
	end

	// Sender: data if supplied, otherwise sync fill in sync modes
	always_comb
	begin
		tx_start = !tx_busy && bit_en && (txv_q || cfg.mode != SLP_ISOCH);
		tx_byte = txv_q ? txd_q : setup_q[SYNC_HI:0]; // RL8
	end

	slp_shifter u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.bit_en(bit_en),
		.start(tx_start),
		.data(tx_byte),
		.frame(cfg),
		.busy(tx_busy),
		.line_out(tx_line)
	);

	// Receiver: hunts for sync, then frames characters with latched settings
	always_comb
	begin
		rsh_d = rsh_q;
		rcnt_d = rcnt_q;
		rbusy_d = rbusy_q;
		rx_cfg_d = rx_cfg_q;
		rxbuf_d = rxbuf_q;
		rxdone_d = rxdone_q && !(acc && !pwrite && paddr == ADDR_RXBUF);
		perr_d = perr_q;
		sync_d = sync_q && !setup_fire;
		if (bit_en)
		begin
			rsh_d = {rx_s_q[1], rsh_q[8:1]};
			if (!sync_q)
			begin
				if (rsh_d[8:1] == setup_q[SYNC_HI:0]) // RL8
				begin
					sync_d = 1'b1;
					rbusy_d = 1'b0;
				end
			end
			else if (!rbusy_q)
			begin
				rx_cfg_d = cfg; // RL9
				// The starting bit is already taken, so count the rest down to zero
				rcnt_d = cfg.len + {3'h0, cfg.par_on} - 4'h2;
				rbusy_d = 1'b1;
			end
			else if (rcnt_q != '0)
				rcnt_d = rcnt_q - 4'h1;
			else
			begin
				rbusy_d = 1'b0;
				rxdone_d = 1'b1;
				// Right justify: total bits now sit at the top of the shift word // RL7
				rxbuf_d = 8'(rsh_d >> (4'h9 - rx_cfg_q.len - {3'h0, rx_cfg_q.par_on}));
				if (rx_cfg_q.par_on)
					perr_d = (^(rsh_d >> (4'h9 - rx_cfg_q.len - 4'h1)))
						== rx_cfg_q.par_even; // RL4 RL6 RL5
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			setup_q <= SETUP_RESET;
			txd_q <= '0;
			txv_q <= 1'b0;
			rxbuf_q <= RXBUF_RESET;
			rxdone_q <= 1'b0;
			perr_q <= 1'b0;
			sync_q <= 1'b0;
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			div_q <= '0;
			ext_s_q <= '0;
			rx_s_q <= '1;
			rx_cfg_q <= '0;
			rsh_q <= '0;
			rcnt_q <= '0;
			rbusy_q <= 1'b0;
			mode_error <= 1'b0;
		end
		else
		begin
			setup_q <= setup_d;
			txd_q <= txd_d;
			txv_q <= txv_d;
			rxbuf_q <= rxbuf_d;
			rxdone_q <= rxdone_d;
			perr_q <= perr_d;
			sync_q <= sync_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			div_q <= div_d;
			ext_s_q <= ext_s_d;
			rx_s_q <= rx_s_d;
			rx_cfg_q <= rx_cfg_d;
			rsh_q <= rsh_d;
			rcnt_q <= rcnt_d;
			rbusy_q <= rbusy_d;
			mode_error <= setup_d[MODE_HI:MODE_LO] == 2'h1; // RL2
		end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	AST_APB_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready)
		else $error("pready late");
	AST_SETUP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		setup_fire |=> setup_q == $past(pwdata[15:0])) // RL1
		else $error("setup not stored");
	AST_LEN_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
		cfg.len == LEN_BASE + {2'h0, setup_q[LEN_HI:LEN_LO]}) // RL3
		else $error("bad length decode");
	AST_MODE_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
		setup_q[MODE_HI:MODE_LO] == MODE_INT_SYNC |-> cfg.mode == SLP_INT_SYNC) // RL1
		else $error("bad mode decode");
	AST_MODE_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		setup_fire && pwdata[MODE_HI:MODE_LO] == 2'h1 |=> mode_error) // RL2
		else $error("mode error missed");
	AST_FILL: assert property (@(posedge pclk) disable iff (!presetn)
		tx_start && !txv_q |-> tx_byte == setup_q[SYNC_HI:0] && cfg.mode != SLP_ISOCH) // RL8
		else $error("bad fill");
	AST_RX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		rbusy_q && rbusy_d |=> rx_cfg_q == $past(rx_cfg_q)) // RL9
		else $error("rx settings changed mid char");
	AST_RX_8BIT: assert property (@(posedge pclk) disable iff (!presetn)
		rxdone_d && !rxdone_q && rx_cfg_q.len == 4'h8 |=>
		rxbuf_q == $past(rx_cfg_q.par_on ? rsh_d[7:0] : rsh_d[8:1])) // RL7
		else $error("8 bit buffer wrong");
	COV_SYNC: cover property (@(posedge pclk) disable iff (!presetn) !sync_q ##1 sync_q);
	COV_RX: cover property (@(posedge pclk) disable iff (!presetn) !rxdone_q ##1 rxdone_q);
	COV_PERR: cover property (@(posedge pclk) disable iff (!presetn) !perr_q ##1 perr_q);
endmodule : slp_line_ctrl

// ===== pkg/slp_pkg.sv
// Package: register map, field positions and mode codes for line parameter control
package slp_pkg;
	localparam logic [11:0] ADDR_SETUP = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_RXBUF = 12'h008;
	localparam logic [11:0] ADDR_TXDATA = 12'h00C;
	localparam int MODE_HI = 13;
	localparam int MODE_LO = 12;
	localparam int LEN_HI = 11;
	localparam int LEN_LO = 10;
	localparam int PAR_ON_BIT = 9;
	localparam int PAR_SENSE_BIT = 8;
	localparam int SYNC_HI = 7;
	localparam logic [15:0] SETUP_RESET = 16'h0000;
	localparam logic [7:0] RXBUF_RESET = 8'hFF;
	localparam logic [1:0] MODE_INT_SYNC = 2'h3;
	localparam logic [1:0] MODE_EXT_SYNC = 2'h2;
	localparam logic [15:0] BIT_DIV = 16'h0010;
	localparam logic [3:0] LEN_BASE = 4'h5;
	typedef enum logic [1:0] {SLP_INT_SYNC, SLP_EXT_SYNC, SLP_ISOCH} slp_mode_e;
	typedef struct packed {
		slp_mode_e mode;
		logic [3:0] len;
		logic par_on;
		logic par_even;
	} slp_frame_s;
endpackage : slp_pkg

// ===== logic/slp_shifter.sv
// Character shifter: serialises one character plus optional parity, LSB first
`timescale 1ns/1ns
module slp_shifter
	import slp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bit_en,
	input wire logic start,
	input wire logic [7:0] data,
	input wire slp_frame_s frame,
	output logic busy,
	output logic line_out
);
	logic [8:0] sh_q, sh_d;
	logic [3:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic out_q, out_d;
	logic [7:0] masked;
	logic [8:0] word;
	logic par;

	always_comb
	begin
		masked = data;
		for (int i = 0; i < 8; i++)
			if (i >= int'(frame.len))
				masked[i] = 1'b0;
		par = ^masked ^ ~frame.par_even; // RL6
		word = {1'b0, masked};
		word[frame.len] = par; // RL4
		sh_d = sh_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		out_d = out_q;
		if (!busy_q && start)
		begin
			// Settings are latched into the shift word here // RL9
			// Start arrives with a bit enable: first bit leaves now, so fill runs back to back
			out_d = word[0];
			sh_d = {1'b1, word[8:1]};
			cnt_d = frame.len + {3'h0, frame.par_on} - 4'h1;
			busy_d = 1'b1;
		end
		else if (busy_q && bit_en)
		begin
			out_d = sh_q[0];
			sh_d = {1'b1, sh_q[8:1]};
			cnt_d = cnt_q - 4'h1;
			busy_d = (cnt_q != 4'h1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			sh_q <= '1;
			cnt_q <= '0;
			busy_q <= 1'b0;
			out_q <= 1'b1;
		end
		else
		begin
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			out_q <= out_d;
		end

	assign busy = busy_q;
	assign line_out = out_q;
endmodule : slp_shifter

// ===== sim/slp_modem.sv
// Modem model: sends and captures serial bits with its own bit clock
`timescale 1ns/1ns
module slp_modem
(
	output logic rx_line,
	output logic ext_clk,
	input logic tx_line
);
	initial
	begin
		rx_line = 1'b1;
		ext_clk = 1'b0;
	end
	// Clock stands still between frames; line rests at mark so no stale bit lingers
	task automatic send(input logic [15:0] bits, input int n);
		// Keep pin changes away from the sampling edge
		#10;
		for (int i = 0; i < n; i++)
		begin
			rx_line = bits[i];
			#200 ext_clk = 1'b1;
			#200 ext_clk = 1'b0;
		end
		rx_line = 1'b1;
	endtask : send
	// Bit is read at the end of its period, long after the synchronised edge shifted it out
	task automatic take(output logic [15:0] bits, input int n);
		bits = '0;
		#10;
		for (int i = 0; i < n; i++)
		begin
			ext_clk = 1'b1;
			#200 ext_clk = 1'b0;
			#200 bits[i] = tx_line;
		end
	endtask : take
endmodule : slp_modem

// ===== sim/test_sync_line_parameter_control.sv
// Bench for line parameter control: register access and received framing
`timescale 1ns/1ns
module test_sync_line_parameter_control
	import slp_pkg::*;
();
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, ext_clk;
	logic tx_line, mode_error, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	int err_total = 0;
	int comparisons = 0;
	slp_line_ctrl #(.BIT_DIVIDE(16'h0004)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
		.ext_clk(ext_clk), .tx_line(tx_line), .mode_error(mode_error));
	slp_modem modem (.rx_line(rx_line), .ext_clk(ext_clk), .tx_line(tx_line));
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic close_out();
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20)
			check(32'h0, 32'h1, "no ready");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic t_tx();
		logic [15:0] got;
		apb(1'b1, ADDR_SETUP, 32'h00000A00);
		apb(1'b1, ADDR_TXDATA, 32'h0000005A);
		modem.take(got, 8);
		// Seven data bits of 5A hold four ones, so odd parity adds a one on top
		check({24'h0, got[7:0]}, 32'h000000DA, "tx 7 bit odd parity");
		apb(1'b1, ADDR_SETUP, 32'h00000C00);
		apb(1'b1, ADDR_TXDATA, 32'h000000A5);
		modem.take(got, 8);
		check({24'h0, got[7:0]}, 32'h000000A5, "tx 8 bit no parity");
		apb(1'b1, ADDR_SETUP, 32'h00002C96);
		modem.take(got, 8);
		check({24'h0, got[7:0]}, 32'h00000096, "tx sync fill");
	endtask : t_tx
	task automatic t_regs();
		apb(1'b0, ADDR_RXBUF, 32'h0);
		check(rd & 32'h000000FF, 32'h000000FF, "rx buffer reset");
		apb(1'b0, ADDR_SETUP, 32'h0);
		check(rd, 32'h0, "setup reads zero");
		apb(1'b0, 12'h010, 32'h0);
		check({31'h0, er}, 32'h1, "unmapped error");
		apb(1'b1, ADDR_SETUP, 32'h00001000);
		check({31'h0, mode_error}, 32'h1, "undefined mode");
		apb(1'b1, ADDR_SETUP, 32'h00003000);
		check({31'h0, mode_error}, 32'h0, "internal mode");
		apb(1'b1, ADDR_SETUP, 32'h00000000);
		check({31'h0, mode_error}, 32'h0, "isochronous mode");
	endtask : t_regs
	task automatic t_rx();
		logic [7:0] d, m;
		logic [15:0] b;
		logic p, en;
		int n, w;
		for (int k = 0; k < 10; k++)
		begin
			n = 5 + (k % 4);
			en = (k < 8);
			d = (8'h5A ^ 8'(k * 37)) & 8'((1 << n) - 1);
			p = (k >= 4 && k < 8) ? ^d : ~^d;
			if (k == 9)
				p = ~p;
			b = 16'(d) | (16'(p) << n);
			w = (n + en > 8) ? 8 : n + en;
			m = 8'((1 << w) - 1);
			apb(1'b1, ADDR_SETUP, {18'h0, 2'b10, 2'(n - 5), en | k == 9, k >= 4 && k < 8, 8'h96});
			modem.send(16'h0096, 8);
			modem.send(b, n + (en | k == 9));
			rd = 32'h0;
			for (int t = 0; t < 20 && rd[0] !== 1'b1; t++)
				apb(1'b0, ADDR_STATUS, 32'h0);
			check({31'h0, rd[0]}, 32'h1, "char framed");
			check({31'h0, rd[1]}, {31'h0, k == 9}, "parity flag");
			apb(1'b0, ADDR_RXBUF, 32'h0);
			check({24'h0, rd[7:0] & m}, {24'h0, b[7:0] & m}, "rx buffer");
		end
	endtask : t_rx
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_tx();
		t_regs();
		t_rx();
		close_out();
	end
	initial
	begin
		#500000;
		err_total++;
		close_out();
	end
endmodule : test_sync_line_parameter_control
